// File: hdl/pmt_port.sv
// What this block does
// RULE_01: Address phase is the first FRAME clock; address and command are driven then.
// RULE_02: Initiator marks active byte lanes on C/BE in every data phase.
// RULE_03: On reads, AD is released after the address clock for one turnaround.
// RULE_04: Target drives AD after turnaround with DEVSEL; TRDY never precedes DEVSEL.
// RULE_05: Target keeps its read AD drivers on until the transaction ends.
// RULE_06: A word moves only when IRDY and TRDY are both asserted.
// RULE_07: Last phase has IRDY asserted with FRAME released; ends when TRDY asserts.
// RULE_08: FRAME may be released only while IRDY is asserted.
// RULE_09: Writes go straight from address to data phase, no turnaround.
// RULE_10: Initiator wait during writes keeps data but withdraws byte enables.
// RULE_11: DMA bursts as initiator keep IRDY asserted, zero wait states.
// RULE_12: Fast back-to-back: later transactions wait once in their first data cycle.
// RULE_13: As target, wait cycles come from holding TRDY deasserted.
// RULE_14: Target waits: config read 2, register and local read 3, writes 0.
// RULE_15: Target serves configuration, register and local peripheral accesses.
// RULE_16: Initiator moves host memory data for the DMA engine in bursts.
// RULE_17: De-multiplexed mode drives parity constantly low.
// RULE_18: De-multiplexed mode drives separate address and direction on the clock edge.
// RULE_19: Initiator starts only when granted and the bus is idle.
`timescale 1ns/1ps
module pmt_port
   import pmt_pkg::*;
(
   input  logic             clk,
   input  logic             srst,
   input  logic             ce,
   input  logic             demuxPin,
   input  logic             idselIn,
   input  logic             gntInN,
   output logic             reqOutN,
   input  logic             frameInN,
   output logic             frameOutN,
   output logic             frameOeN,
   input  logic             irdyInN,
   output logic             irdyOutN,
   output logic             irdyOeN,
   input  logic             trdyInN,
   output logic             trdyOutN,
   output logic             trdyOeN,
   input  logic             devselInN,
   output logic             devselOutN,
   output logic             devselOeN,
   input  logic [DW-1:0]    adIn,
   output logic [DW-1:0]    adOut,
   output logic             adOeN,
   input  logic [BEW-1:0]   cbeInN,
   output logic [BEW-1:0]   cbeOutN,
   output logic             cbeOeN,
   output logic             parOut,
   output logic             parOeN,
   input  logic [DW-1:0]    lAddrIn,
   output logic [DW-1:0]    lAddrOut,
   input  logic             wrIn,
   output logic             wrOut,
   output logic             lAddrOeN,
   input  logic             dmaStart,
   input  logic             dmaWrite,
   input  logic             dmaB2b,
   input  logic [DW-1:0]    dmaAddr,
   input  logic [LENW-1:0]  dmaLen,
   output logic             dmaBusy,
   output logic             dmaDone,
   output logic             rdValid,
   output logic [DW-1:0]    rdData,
   input  logic             wrValid,
   input  logic [DW-1:0]    wrData,
   output logic             wrReady,
   input  logic [BASEW-1:0] tgtBase,
   input  logic [DW-1:0]    tgtRdata,
   output logic             tgtReq,
   output logic             tgtWrite,
   output logic [1:0]       tgtKind,
   output logic [DW-1:0]    tgtAddr,
   output logic [DW-1:0]    tgtWdata,
   output logic [BEW-1:0]   tgtBe
);
   localparam int SW = 2*DW + BEW + 8;

   pmt_regs_t      q_r, q_nxt;
   logic [SW-1:0]  s1_r, s2_r;
   logic           sDemux, sIdsel, sGntN, sFrameN, sIrdyN, sTrdyN, sDevselN, sWr;
   logic [DW-1:0]  sAd, sLAddr, aIn;
   logic [BEW-1:0] sCbeN;
   logic           xfer, cfgHit, memHit, startOk;
   logic [1:0]     rdWait;
   pmt_kind_t      hitKind;

   pmt_fifo_if fq ();

   pmt_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk  (clk),
      .srst (srst),
      .ce   (ce),
      .f    (fq.store)
   );

   // Pins come from other devices, so every one passes two flops first
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s1_r <= '1; // Idle level, so no false frame edge after reset
         s2_r <= '1;
      end
      else if (ce)
      begin
         s1_r <= {demuxPin, idselIn, gntInN, frameInN, irdyInN, trdyInN, devselInN, cbeInN, adIn, lAddrIn, wrIn};
         s2_r <= s1_r;
      end
   end
   assign {sDemux, sIdsel, sGntN, sFrameN, sIrdyN, sTrdyN, sDevselN, sCbeN, sAd, sLAddr, sWr} = s2_r;

   // Write data from the DMA side is buffered until a whole burst is ready
   assign fq.inValid = wrValid;
   assign fq.inData  = wrData;
   assign wrReady    = fq.inReady;

   // RULE_06 both ready
   assign xfer = !sIrdyN && !sTrdyN;

   // RULE_18 address source
   assign aIn    = sDemux ? sLAddr : sAd;
   // RULE_15 decode targets
   assign cfgHit = sIdsel && (sCbeN == CMD_CFGRD || sCbeN == CMD_CFGWR);
   assign memHit = (sCbeN == CMD_MEMRD || sCbeN == CMD_MEMWR) && (aIn[DW-1:BAR_LSB] == tgtBase);
   assign hitKind = cfgHit ? TK_CFG : (aIn[LB_SEL_BIT] ? TK_LB : TK_REG);
   // RULE_14 read wait states
   assign rdWait = (hitKind == TK_CFG) ? WAIT_CFG_RD : WAIT_REG_RD;
   // RULE_19 granted and idle
   assign startOk = q_r.busy && !sGntN && (q_r.b2bOwn || (sFrameN && sIrdyN))
                    && (!q_r.mWrite || fq.level >= q_r.len);

   // Bus engine: one state walk for both initiator and target roles
   always_comb
   begin
      q_nxt         = q_r;
      q_nxt.done    = 1'b0;
      q_nxt.rdValid = 1'b0;
      q_nxt.tReq    = 1'b0;
      q_nxt.frPrevN = sFrameN;
      fq.outReady   = 1'b0;
      // RULE_17 parity or low
      q_nxt.par     = sDemux ? 1'b0 : ^{q_r.ad, q_r.cbe};
      q_nxt.parOeN  = q_r.adOeN;
      case (q_r.st)
         ST_IDLE:
         begin
            if (dmaStart && !q_r.busy)
            begin
               q_nxt.busy   = 1'b1;
               q_nxt.reqN   = 1'b0;
               q_nxt.addr   = dmaAddr;
               q_nxt.len    = dmaLen;
               q_nxt.mWrite = dmaWrite;
            end
            if (startOk)
            begin
               // RULE_01 address and command
               q_nxt.st      = ST_MADDR;
               q_nxt.frameN  = 1'b0;
               q_nxt.irdyN   = 1'b1;
               q_nxt.mOeN    = 1'b0;
               q_nxt.ad      = q_r.addr;
               q_nxt.adOeN   = 1'b0;
               q_nxt.cbe     = q_r.mWrite ? CMD_MEMWR : CMD_MEMRD;
               q_nxt.cbeOeN  = 1'b0;
               // RULE_18 demux address out
               q_nxt.lAddr   = q_r.addr;
               q_nxt.wr      = q_r.mWrite;
               q_nxt.lOeN    = !sDemux;
               q_nxt.b2bWait = q_r.b2bOwn;
               q_nxt.b2bOwn  = 1'b0;
            end
            else if (!sFrameN && q_r.frPrevN && (cfgHit || memHit))
            begin
               // RULE_04 devsel first
               q_nxt.st      = ST_TWAIT;
               q_nxt.devselN = 1'b0;
               q_nxt.trdyN   = 1'b1;
               q_nxt.tOeN    = 1'b0;
               q_nxt.kind    = hitKind;
               q_nxt.tWrite  = sCbeN[0];
               q_nxt.tAddr   = aIn;
               q_nxt.waitCnt = sCbeN[0] ? WAIT_WR : rdWait;
               q_nxt.tReq    = !sCbeN[0];
            end
         end
         ST_MADDR:
         begin
            // RULE_03 read turnaround
            // RULE_09 write goes on
            q_nxt.st     = ST_MDATA;
            q_nxt.adOeN  = !q_r.mWrite;
            q_nxt.ad     = fq.outData;
            q_nxt.lOeN   = 1'b1;
            // RULE_12 one b2b wait
            q_nxt.irdyN  = q_r.b2bWait;
            // RULE_02 byte lanes marked
            q_nxt.cbe    = q_r.b2bWait ? BE_NONE : BE_ALL;
            // RULE_08 release with irdy
            q_nxt.frameN = (q_r.len == LEN_ONE) && !q_r.b2bWait;
         end
         ST_MDATA:
         begin
            if (q_r.mWrite)
               q_nxt.ad = fq.outData;
            if (q_r.b2bWait)
            begin
               q_nxt.b2bWait = 1'b0;
               q_nxt.irdyN   = 1'b0;
               q_nxt.cbe     = BE_ALL;
               q_nxt.frameN  = (q_r.len == LEN_ONE);
            end
            // RULE_16 burst data move
            else if (xfer)
            begin
               fq.outReady   = q_r.mWrite;
               q_nxt.rdValid = !q_r.mWrite;
               q_nxt.rdData  = sAd;
               q_nxt.len     = q_r.len - 1'b1;
               q_nxt.addr    = q_r.addr + ADDR_STEP;
               // RULE_07 last phase done
               if (q_r.frameN)
               begin
                  q_nxt.st     = ST_TEND;
                  q_nxt.irdyN  = 1'b1;
                  q_nxt.busy   = 1'b0;
                  q_nxt.done   = 1'b1;
                  q_nxt.reqN   = 1'b1;
                  q_nxt.b2bOwn = dmaB2b;
               end
               else
                  q_nxt.frameN = (q_r.len == LEN_TWO);
            end
         end
         ST_TWAIT:
         begin
            // RULE_05 drivers stay on
            q_nxt.adOeN = q_r.tWrite;
            q_nxt.ad    = tgtRdata;
            // RULE_13 hold trdy off
            if (q_r.waitCnt == WAIT_WR)
            begin
               q_nxt.st    = ST_TDATA;
               q_nxt.trdyN = 1'b0;
            end
            else
               q_nxt.waitCnt = q_r.waitCnt - WAIT_ONE;
         end
         ST_TDATA:
         begin
            if (xfer)
            begin
               q_nxt.tReq   = q_r.tWrite;
               q_nxt.tWdata = sAd;
               q_nxt.tBe    = sCbeN;
               q_nxt.trdyN  = 1'b1;
               if (sFrameN)
               begin
                  q_nxt.st      = ST_TEND;
                  q_nxt.devselN = 1'b1;
               end
               else
               begin
                  q_nxt.st      = ST_TWAIT;
                  q_nxt.tAddr   = q_r.tAddr + ADDR_STEP;
                  q_nxt.waitCnt = q_r.tWrite ? WAIT_WR : (q_r.kind == TK_CFG ? WAIT_CFG_RD : WAIT_REG_RD);
                  q_nxt.tReq    = !q_r.tWrite;
               end
            end
         end
         ST_TEND:
         begin
            // Driven FRAME, IRDY, TRDY and DEVSEL idle high one clock before they float
            q_nxt.st     = ST_IDLE;
            q_nxt.mOeN   = 1'b1;
            q_nxt.tOeN   = 1'b1;
            q_nxt.adOeN  = 1'b1;
            q_nxt.cbeOeN = 1'b1;
            q_nxt.frameN = 1'b1;
         end
         default:
            q_nxt = REGS_RST;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         q_r <= REGS_RST;
      else if (ce)
         q_r <= q_nxt;
   end

   // Every output except wrReady is a field of the state register
   assign reqOutN    = q_r.reqN;
   assign frameOutN  = q_r.frameN;
   assign irdyOutN   = q_r.irdyN;
   assign frameOeN   = q_r.mOeN;
   assign irdyOeN    = q_r.mOeN;
   assign trdyOutN   = q_r.trdyN;
   assign devselOutN = q_r.devselN;
   assign trdyOeN    = q_r.tOeN;
   assign devselOeN  = q_r.tOeN;
   assign adOut      = q_r.ad;
   assign adOeN      = q_r.adOeN;
   assign cbeOutN    = q_r.cbe;
   assign cbeOeN     = q_r.cbeOeN;
   assign parOut     = q_r.par;
   assign parOeN     = q_r.parOeN;
   assign lAddrOut   = q_r.lAddr;
   assign wrOut      = q_r.wr;
   assign lAddrOeN   = q_r.lOeN;
   assign dmaBusy    = q_r.busy;
   assign dmaDone    = q_r.done;
   assign rdValid    = q_r.rdValid;
   assign rdData     = q_r.rdData;
   assign tgtReq     = q_r.tReq;
   assign tgtWrite   = q_r.tWrite;
   assign tgtKind    = q_r.kind;
   assign tgtAddr    = q_r.tAddr;
   assign tgtWdata   = q_r.tWdata;
   assign tgtBe      = q_r.tBe;

   // Checks on the protocol the block drives
   sequence seqCfgRdWait;
      q_r.trdyN [*3] ##1 !q_r.trdyN;
   endsequence
   sequence seqRegRdWait;
      q_r.trdyN [*4] ##1 !q_r.trdyN;
   endsequence
   sequence seqB2bWait;
      q_r.irdyN ##1 !q_r.irdyN;
   endsequence

   AST_ADDR_PHASE: assert property (@(posedge clk) disable iff (srst) // RULE_01
      (q_r.st == ST_MADDR) |-> (!q_r.frameN && !q_r.adOeN && q_r.ad == $past(q_r.addr)
                                && (q_r.cbe == CMD_MEMRD || q_r.cbe == CMD_MEMWR)))
      else $error("address phase without address or command");
   AST_TURNAROUND: assert property (@(posedge clk) disable iff (srst || !ce) // RULE_03
      (q_r.st == ST_MADDR && !q_r.mWrite) |=> q_r.adOeN)
      else $error("AD still driven after read address clock");
   AST_TRDY_AFTER_DEVSEL: assert property (@(posedge clk) disable iff (srst) // RULE_04
      (!q_r.trdyN && !q_r.tOeN) |-> (!q_r.devselN && $past(!q_r.devselN)))
      else $error("TRDY asserted without DEVSEL");
   AST_AD_HOLD: assert property (@(posedge clk) disable iff (srst || !ce) // RULE_05
      ((q_r.st == ST_TWAIT || q_r.st == ST_TDATA) && !q_r.adOeN) |=> !q_r.adOeN)
      else $error("target AD drivers dropped mid transaction");
   AST_NO_WAIT: assert property (@(posedge clk) disable iff (srst || !ce) // RULE_11
      (q_r.st == ST_MDATA && !q_r.irdyN) |=> (q_r.st != ST_MDATA || !q_r.irdyN))
      else $error("initiator wait state in burst");
   AST_B2B_WAIT: assert property (@(posedge clk) disable iff (srst || !ce) // RULE_12
      (q_r.st == ST_MADDR && q_r.b2bWait) |=> seqB2bWait)
      else $error("back-to-back first data cycle wait wrong");
   AST_FRAME_LAST: assert property (@(posedge clk) disable iff (srst) // RULE_08
      (q_r.st == ST_MDATA && q_r.frameN) |-> !q_r.irdyN)
      else $error("FRAME released while IRDY deasserted");
   AST_CFG_RD_WAIT: assert property (@(posedge clk) disable iff (srst || !ce) // RULE_14
      (q_r.tReq && q_r.st == ST_TWAIT && q_r.kind == TK_CFG && q_r.waitCnt == WAIT_CFG_RD) |-> seqCfgRdWait)
      else $error("configuration read wait count wrong");
   AST_REG_RD_WAIT: assert property (@(posedge clk) disable iff (srst || !ce) // RULE_14
      (q_r.tReq && q_r.st == ST_TWAIT && q_r.kind != TK_CFG && q_r.waitCnt == WAIT_REG_RD) |-> seqRegRdWait)
      else $error("register or local read wait count wrong");
   AST_PAR_LOW: assert property (@(posedge clk) disable iff (srst || !ce) // RULE_17
      $past(sDemux) |-> !q_r.par)
      else $error("parity driven in de-multiplexed mode");
   AST_START_GNT: assert property (@(posedge clk) disable iff (srst || !ce) // RULE_19
      (q_r.st == ST_MADDR && $past(q_r.st) == ST_IDLE) |-> ($past(sGntN) == 1'b0))
      else $error("transaction started without grant");
endmodule : pmt_port

// File: hdl/pmt_pkg.sv
package pmt_pkg;
   // Bus widths and burst length
   localparam int DW         = 32;
   localparam int BEW        = 4;
   localparam int LENW       = 5;
   localparam int FIFO_DEPTH = 16;
   // Memory window: upper address bits match the base, one bit splits it
   localparam int BAR_LSB    = 17;
   localparam int LB_SEL_BIT = 16;
   localparam int BASEW      = DW - BAR_LSB;
   localparam logic [DW-1:0]   ADDR_STEP = 32'h0000_0004;
   localparam logic [LENW-1:0] LEN_ONE   = 5'h01;
   localparam logic [LENW-1:0] LEN_TWO   = 5'h02;
   // Bus commands and byte enables (active low)
   localparam logic [BEW-1:0] CMD_MEMRD = 4'h6;
   localparam logic [BEW-1:0] CMD_MEMWR = 4'h7;
   localparam logic [BEW-1:0] CMD_CFGRD = 4'ha;
   localparam logic [BEW-1:0] CMD_CFGWR = 4'hb;
   localparam logic [BEW-1:0] BE_ALL    = 4'h0;
   localparam logic [BEW-1:0] BE_NONE   = 4'hf;
   // Target wait states
   localparam logic [1:0] WAIT_CFG_RD = 2'h2;
   localparam logic [1:0] WAIT_REG_RD = 2'h3;
   localparam logic [1:0] WAIT_WR     = 2'h0;
   localparam logic [1:0] WAIT_ONE    = 2'h1;

   typedef enum logic [2:0] {ST_IDLE, ST_MADDR, ST_MDATA, ST_TWAIT, ST_TDATA, ST_TEND} pmt_state_t;
   typedef enum logic [1:0] {TK_CFG, TK_REG, TK_LB} pmt_kind_t;

   typedef struct packed {
      pmt_state_t      st;
      logic            reqN;
      logic            frameN;
      logic            irdyN;
      logic            trdyN;
      logic            devselN;
      logic            mOeN;
      logic            tOeN;
      logic [DW-1:0]   ad;
      logic            adOeN;
      logic [BEW-1:0]  cbe;
      logic            cbeOeN;
      logic            par;
      logic            parOeN;
      logic [DW-1:0]   lAddr;
      logic            wr;
      logic            lOeN;
      logic            frPrevN;
      logic [DW-1:0]   addr;
      logic [LENW-1:0] len;
      logic            mWrite;
      logic            b2bOwn;
      logic            b2bWait;
      logic [1:0]      waitCnt;
      pmt_kind_t       kind;
      logic            tWrite;
      logic            busy;
      logic            done;
      logic            rdValid;
      logic [DW-1:0]   rdData;
      logic            tReq;
      logic [DW-1:0]   tAddr;
      logic [DW-1:0]   tWdata;
      logic [BEW-1:0]  tBe;
   } pmt_regs_t;

   localparam pmt_regs_t REGS_RST = '{st: ST_IDLE, kind: TK_CFG, reqN: 1'b1, frameN: 1'b1, irdyN: 1'b1,
                                      trdyN: 1'b1, devselN: 1'b1, mOeN: 1'b1, tOeN: 1'b1, adOeN: 1'b1,
                                      cbe: BE_NONE, cbeOeN: 1'b1, parOeN: 1'b1, lOeN: 1'b1, frPrevN: 1'b1,
                                      default: '0};
endpackage : pmt_pkg

// File: hdl/pmt_fifo_if.sv
`timescale 1ns/1ps
interface pmt_fifo_if;
   import pmt_pkg::*;
   logic            inValid;
   logic            inReady;
   logic [DW-1:0]   inData;
   logic            outValid;
   logic            outReady;
   logic [DW-1:0]   outData;
   logic [LENW-1:0] level;
   modport fill  (output inValid, inData, outReady, input inReady, outValid, outData, level);
   modport store (input inValid, inData, outReady, output inReady, outValid, outData, level);
endinterface : pmt_fifo_if

// File: hdl/pmt_fifo.sv
`timescale 1ns/1ps
module pmt_fifo
   import pmt_pkg::*;
#(
   parameter int W     = DW,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input  logic       clk,
   input  logic       srst,
   input  logic       ce,
   pmt_fifo_if.store  f
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem_r [DEPTH];
   logic [W-1:0]  mem_nxt [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]   cnt_r, cnt_nxt;
   logic          rdy_r, rdy_nxt;
   logic          push, pop;

   // Ready is registered so the filling side never sees a combinational path
   assign push       = f.inValid && rdy_r;
   assign pop        = f.outValid && f.outReady;
   assign f.inReady  = rdy_r;
   assign f.outValid = (cnt_r != '0);
   assign f.outData  = mem_r[rp_r];
   assign f.level    = LENW'(cnt_r);

   // Pointer, count and storage update
   always_comb
   begin
      mem_nxt = mem_r;
      wp_nxt  = wp_r;
      rp_nxt  = rp_r;
      cnt_nxt = cnt_r;
      if (push)
      begin
         mem_nxt[wp_r] = f.inData;
         wp_nxt        = wp_r + 1'b1;
      end
      if (pop)
         rp_nxt = rp_r + 1'b1;
      if (push && !pop)
         cnt_nxt = cnt_r + 1'b1;
      else if (pop && !push)
         cnt_nxt = cnt_r - 1'b1;
      rdy_nxt = (cnt_nxt < (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
         rdy_r <= 1'b0;
      end
      else if (ce)
      begin
         mem_r <= mem_nxt;
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
         rdy_r <= rdy_nxt;
      end
   end
endmodule : pmt_fifo

// File: tb/pmt_host_model.sv
`timescale 1ns/1ps
module pmt_host_model
   import pmt_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           srst,
   input  wire logic [3:0]     gap,
   input  wire logic           reqN,
   output logic                gntN,
   input  wire logic           frameN,
   input  wire logic           irdyN,
   input  wire logic [DW-1:0]  addr,
   input  wire logic [DW-1:0]  ad,
   input  wire logic [BEW-1:0] cbe,
   output logic                trdyN,
   output logic                devselN,
   output logic [DW-1:0]       adOut,
   output logic                adOe
);
   logic [DW-1:0] mem [0:15];
   logic          act;
   logic          rd;
   logic          frPrev;
   logic [3:0]    idx;
   logic [3:0]    cnt;

   assign gntN = reqN;

   // Host memory target; ready comes in pulses so a slow initiator view keeps pace
   always @(posedge clk)
   begin
      frPrev <= frameN;
      adOut  <= mem[idx];
      if (srst)
      begin
         act     <= 1'b0;
         trdyN   <= 1'b1;
         devselN <= 1'b1;
         adOe    <= 1'b0;
      end
      else if (!act)
      begin
         if (frPrev && !frameN && addr < 32'h0001_0000 && (cbe | 4'h1) == CMD_MEMWR)
         begin
            act     <= 1'b1;
            rd      <= (cbe == CMD_MEMRD);
            idx     <= addr[5:2];
            devselN <= 1'b0;
            cnt     <= gap;
         end
      end
      else
      begin
         // drive AD only after the turnaround
         adOe <= rd;
         // transfer, last one when frame is high
         if (!trdyN && !irdyN)
         begin
            if (!rd)
               mem[idx] <= ad;
            idx   <= idx + 4'h1;
            trdyN <= 1'b1;
            cnt   <= gap;
            if (frameN)
            begin
               act     <= 1'b0;
               devselN <= 1'b1;
               adOe    <= 1'b0;
            end
         end
         else if (cnt == 4'h0)
            trdyN <= 1'b0;
         else
            cnt <= cnt - 4'h1;
      end
   end
endmodule : pmt_host_model

// File: tb/pmt_port_tb.sv
`timescale 1ns/1ps
module pmt_port_tb
   import pmt_pkg::*;
;
   localparam logic [DW-1:0]    KEY  = 32'h5a5a_0000;
   localparam logic [BASEW-1:0] BASE = 15'h0012;
   logic             clk = 1'b0, srst = 1'b1, ce = 1'b1, demuxPin = 1'b0, idselIn = 1'b0;
   logic             hFrameN = 1'b1, hIrdyN = 1'b1, hAdOe = 1'b0, hWr = 1'b0;
   logic             dmaStart = 1'b0, dmaWrite = 1'b0, dmaB2b = 1'b0, wrValid = 1'b0;
   logic [BEW-1:0]   hCbe = BE_NONE;
   logic [DW-1:0]    hAd = '0, dmaAddr = '0, wrData = '0, adLast = '0;
   logic [LENW-1:0]  dmaLen = LEN_ONE;
   logic [3:0]       gap = 4'h3;
   logic [BASEW-1:0] tgtBase = BASE;
   logic             gntInN, frameInN, irdyInN, trdyInN, devselInN, mTrdyN, mDevselN, mAdOe, wrIn;
   logic [DW-1:0]    adIn, mAd, lAddrIn, tgtRdata, mAddr;
   logic [BEW-1:0]   cbeInN, cbeOutN, tgtBe;
   logic             reqOutN, frameOutN, frameOeN, irdyOutN, irdyOeN, trdyOutN, trdyOeN, devselOutN;
   logic             devselOeN, adOeN, cbeOeN, parOut, parOeN, wrOut, lAddrOeN, dmaBusy, dmaDone;
   logic             rdValid, wrReady, tgtReq, tgtWrite, capWr, seenWr, frLow = 1'b0;
   logic [1:0]       tgtKind, capK;
   logic [DW-1:0]    adOut, lAddrOut, rdData, tgtAddr, tgtWdata, capW, seenLa;
   logic [DW-1:0]    rdQ[$];
   int               error_cnt = 0, tests_run = 0, parBad = 0, iWait = 0;

   always #10 clk = ~clk;

   // Wire levels from whoever drives; a released AD shows a changing pattern
   assign frameInN  = frameOeN ? hFrameN : frameOutN;
   assign irdyInN   = irdyOeN ? hIrdyN : irdyOutN;
   assign trdyInN   = trdyOeN ? mTrdyN : trdyOutN;
   assign devselInN = devselOeN ? mDevselN : devselOutN;
   assign cbeInN    = cbeOeN ? hCbe : cbeOutN;
   assign adIn      = !adOeN ? adOut : mAdOe ? mAd : hAdOe ? hAd : ~adLast;
   assign lAddrIn   = lAddrOeN ? hAd : lAddrOut;
   assign wrIn      = lAddrOeN ? hWr : wrOut;
   assign mAddr     = demuxPin ? lAddrIn : adIn;
   assign tgtRdata  = tgtAddr ^ KEY;

   pmt_port i_dut (.clk, .srst, .ce, .demuxPin, .idselIn, .gntInN, .reqOutN, .frameInN, .frameOutN, .frameOeN,
      .irdyInN, .irdyOutN, .irdyOeN, .trdyInN, .trdyOutN, .trdyOeN, .devselInN, .devselOutN, .devselOeN,
      .adIn, .adOut, .adOeN, .cbeInN, .cbeOutN, .cbeOeN, .parOut, .parOeN, .lAddrIn, .lAddrOut, .wrIn,
      .wrOut, .lAddrOeN, .dmaStart, .dmaWrite, .dmaB2b, .dmaAddr, .dmaLen, .dmaBusy, .dmaDone, .rdValid,
      .rdData, .wrValid, .wrData, .wrReady, .tgtBase, .tgtRdata, .tgtReq, .tgtWrite, .tgtKind, .tgtAddr,
      .tgtWdata, .tgtBe);

   pmt_host_model i_host (.clk, .srst, .gap, .reqN(reqOutN), .gntN(gntInN), .frameN(frameInN),
      .irdyN(irdyInN), .addr(mAddr), .ad(adIn), .cbe(cbeInN), .trdyN(mTrdyN), .devselN(mDevselN),
      .adOut(mAd), .adOe(mAdOe));

   // Pulses and initiator wait cycles are caught as they pass
   always @(posedge clk)
   begin
      adLast <= adIn;
      frLow  <= !frameOeN && !frameOutN;
      if (rdValid)
         rdQ.push_back(rdData);
      if (tgtReq)
      begin
         capK  <= tgtKind;
         capW  <= tgtWdata;
         capWr <= tgtWrite;
      end
      if (!parOeN && demuxPin && parOut !== 1'b0)
         parBad <= parBad + 1;
      if (!lAddrOeN)
      begin
         seenLa <= lAddrOut;
         seenWr <= wrOut;
      end
      if (frLow && !frameOeN && !frameOutN && !irdyOeN && irdyOutN)
         iWait <= iWait + ((cbeOutN == BE_NONE) ? 1 : 16); // lanes withdrawn
   end

   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   task automatic giveUp;
      error_cnt++;
      $display("Error at %0t: wait ran out", $time);
      report_and_stop();
   endtask : giveUp

   // Single-word host access; counts claim cycles before ready
   task automatic hostAcc(input logic [BEW-1:0] cmd, input logic [DW-1:0] a, input int expW, input logic [1:0] k);
      int w = 0, n = 0;
      logic [DW-1:0] rd;
      @(negedge clk);
      idselIn = (cmd == CMD_CFGRD || cmd == CMD_CFGWR);
      hFrameN = 1'b0;
      hAd = a;
      hAdOe = 1'b1;
      hCbe = cmd;
      hWr = cmd[0];
      @(negedge clk);
      // last phase at once, lanes from address
      hFrameN = 1'b1;
      hIrdyN = 1'b0;
      hCbe = {2'b00, a[3:2]};
      // reads release AD, writes put data on it
      hAdOe = cmd[0];
      hAd = ~a;
      while (!(trdyOeN === 1'b0 && trdyOutN === 1'b0))
      begin
         w = w + ((devselOeN === 1'b0 && devselOutN === 1'b0) ? 1 : 0);
         n++;
         if (n > 40)
            giveUp();
         @(negedge clk);
      end
      rd = adOut;
      @(negedge clk);
      hIrdyN = 1'b1;
      hCbe = BE_NONE;
      hAdOe = 1'b0;
      idselIn = 1'b0;
      repeat (8) @(negedge clk);
      chk(w, expW);
      chk(capK, k);
      chk(capWr, cmd[0]);
      chk(tgtAddr, a);
      chk(tgtBe, {2'b00, a[3:2]});
      if (cmd[0])
         chk(capW, ~a);
      else
         chk(rd, a ^ KEY);
   endtask : hostAcc

   task automatic startDma(input logic wr, input logic [DW-1:0] a, input logic [LENW-1:0] len);
      int n;
      @(negedge clk);
      dmaWrite = wr;
      dmaAddr = a;
      dmaLen = len;
      dmaStart = 1'b1;
      @(negedge clk);
      dmaStart = 1'b0;
      for (n = 0; dmaDone !== 1'b1; n++)
      begin
         if (n > 600)
            giveUp();
         @(negedge clk);
      end
   endtask : startDma

   task automatic push(input logic [DW-1:0] d, input logic expReady);
      @(negedge clk);
      chk(wrReady, expReady);
      wrValid = 1'b1;
      wrData = d;
      @(negedge clk);
      wrValid = 1'b0;
   endtask : push

   initial
   begin
      repeat (6) @(negedge clk);
      srst = 1'b0;
      repeat (3) @(negedge clk);
      chk({frameOeN, trdyOeN, devselOeN, adOeN, cbeOeN, reqOutN, dmaBusy, cbeOutN}, 11'h7ef);
      hostAcc(CMD_CFGRD, 32'h0000_0010, 3, TK_CFG);
      hostAcc(CMD_CFGWR, 32'h0000_0014, 1, TK_CFG);
      hostAcc(CMD_MEMRD, {BASE, 17'h00040}, 4, TK_REG);
      hostAcc(CMD_MEMWR, {BASE, 17'h00044}, 1, TK_REG);
      hostAcc(CMD_MEMRD, {BASE, 17'h10080}, 4, TK_LB);
      hostAcc(CMD_MEMWR, {BASE, 17'h10084}, 1, TK_LB);
      // Demux write burst of a full buffer against a slow target
      demuxPin = 1'b1;
      for (int i = 0; i < FIFO_DEPTH; i++)
         push(32'hd000_0000 + i, 1'b1);
      push(32'hdead_beef, 1'b0);
      startDma(1'b1, 32'h0000_0100, 5'h10);
      for (int i = 0; i < FIFO_DEPTH; i++)
         chk(i_host.mem[i], 32'hd000_0000 + i);
      chk(parBad, 0);
      chk(seenLa, 32'h0000_0100);
      chk(seenWr, 1'b1);
      demuxPin = 1'b0;
      // Fast back-to-back pair of single writes
      push(32'hb000_0000, 1'b1);
      push(32'hb000_0001, 1'b1);
      dmaB2b = 1'b1;
      startDma(1'b1, 32'h0000_0180, LEN_ONE);
      dmaB2b = 1'b0;
      startDma(1'b1, 32'h0000_0184, LEN_ONE);
      chk(i_host.mem[1], 32'hb000_0001);
      // Read burst with longer target gaps
      gap = 4'h5;
      rdQ.delete();
      startDma(1'b0, 32'h0000_0108, LEN_TWO);
      repeat (2) @(negedge clk);
      chk(rdQ.size(), 2);
      chk(rdQ[0], 32'hd000_0002);
      chk(rdQ[1], 32'hd000_0003);
      chk(iWait, 1);
      report_and_stop();
   end
endmodule : pmt_port_tb
